// ---- include/cps_consts.svh ----
// Purpose: Named offsets, fields and timing figures for the cable port state block.
// Assumes: 50 MHz pclk and a 32-bit APB register window.
// Notes:   Timing figures are kept in their own units; cycle counts derive from them.
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define CPS_OFF_CTRL    12'h000
`define CPS_OFF_CMD     12'h004
`define CPS_OFF_STATUS  12'h008

// ----------------------------------------------------------------------------
// Register fields
// ----------------------------------------------------------------------------
`define CPS_CTRL_DIS_LSB   0
`define CPS_CTRL_INTEN_LSB 2
`define CPS_CMD_SUSP_LSB   0
`define CPS_CMD_RES_LSB    2
`define CPS_CMD_RPKT_BIT   4
`define CPS_CMD_FCLR_LSB   5
`define CPS_ST_STATE_W     3
`define CPS_ST_FAULT_LSB   6
`define CPS_ST_PD_BIT      8
`define CPS_ST_LACT_BIT    9
`define CPS_ST_LPS_BIT     10
`define CPS_CTRL_RESET     4'h0

// ----------------------------------------------------------------------------
// Timing figures and clock rate
// ----------------------------------------------------------------------------
`define CPS_CLK_MHZ        50
`define CPS_PD_WAIT_MS     680
`define CPS_WAKE_MS        11
`define CPS_BIAS_HS_US     1300
`define CPS_LINK_IDLE_NS   2560

`endif

// ---- include/cps_pkg.sv ----
// Purpose: Types shared by the cable port state block.
// Assumes: Two cable ports.
// Notes:   Port states are Gray coded along disconnected, resuming, active, suspended.
package cps_pkg;

  // --------------------------------------------------------------------------
  // Port state
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CPS_DISC    = 3'h0,
    CPS_RESUME  = 3'h1,
    CPS_ACTIVE  = 3'h3,
    CPS_SUSP    = 3'h2,
    CPS_DISABLE = 3'h6
  } cps_state_e;

  // --------------------------------------------------------------------------
  // Per-port analog front-end enables
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic bias_out;     // Drive cable bias on the A side.
    logic conn_det_en;  // Connection detector running.
    logic bias_det_en;  // Peer bias detector running on the B side.
    logic a_tx_en;      // A pair driver: arbitration or outgoing strobe.
    logic a_rx_en;      // A pair receiver: arbitration, incoming data, speed.
    logic b_tx_en;      // B pair driver: arbitration, outgoing data, speed.
    logic b_rx_en;      // B pair receiver: arbitration or incoming strobe.
  } cps_fe_s;

endpackage

// ---- core/cps_port.sv ----
// Purpose: State register, fault bit and bias handshake timer for one cable port.
// Assumes: Inputs are already synchronised to pclk.
// Notes:   Disable forces the port off from any state.
`include "cps_consts.svh"

module cps_port #(
  parameter int HS_CYCLES = `CPS_BIAS_HS_US * `CPS_CLK_MHZ
) (
  // Clock and reset
  input  wire logic               pclk,
  input  wire logic               presetn,
  // Control and detectors
  input  wire logic               disable_req,
  input  wire logic               connect,
  input  wire logic               bias,
  input  wire logic               go_suspend,
  input  wire logic               go_resume,
  input  wire logic               fault_clr,
  // Status
  output cps_pkg::cps_state_e     state,
  output logic                    fault,
  output logic                    local_resume
);

  localparam int HW = $clog2(HS_CYCLES + 1);

  logic [HW-1:0] hs_cnt;
  logic          hs_done;
  logic          susp_bias_clr;

  // Elaboration check on the handshake window.
  if (HS_CYCLES < 1) begin : g_chk
    $error("HS_CYCLES must be at least one");
  end

  assign hs_done       = (hs_cnt == HW'(HS_CYCLES));
  assign susp_bias_clr = (state == cps_pkg::CPS_SUSP) && fault_clr && bias;

  // A resume started locally rather than by a packet fans out to other ports when the node is not a boundary node.
  assign local_resume = ((state == cps_pkg::CPS_DISC) && connect) ||
                        (susp_bias_clr && !go_resume);

  // Bias handshake timer runs only while resuming.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_cnt <= '0;
    end else if (state == cps_pkg::CPS_RESUME && !hs_done) begin
      hs_cnt <= hs_cnt + HW'(1);
    end else if (state != cps_pkg::CPS_RESUME) begin
      hs_cnt <= '0;
    end
  end

  // Port state; reset lands in disconnected.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= cps_pkg::CPS_DISC;
    end else if (disable_req) begin
      state <= cps_pkg::CPS_DISABLE;
    end else begin
      unique case (state)
        cps_pkg::CPS_DISABLE: state <= cps_pkg::CPS_DISC;
        cps_pkg::CPS_DISC: begin
          if (connect) state <= cps_pkg::CPS_RESUME;
        end
        cps_pkg::CPS_RESUME: begin
          if (bias) state <= cps_pkg::CPS_ACTIVE;
          else if (hs_done) state <= cps_pkg::CPS_SUSP;
        end
        cps_pkg::CPS_ACTIVE: begin
          if (go_suspend) state <= cps_pkg::CPS_SUSP;
          else if (!bias) state <= cps_pkg::CPS_DISC;
        end
        cps_pkg::CPS_SUSP: begin
          if (!connect) state <= cps_pkg::CPS_DISC;
          else if (go_resume || susp_bias_clr) state <= cps_pkg::CPS_RESUME;
        end
        default: state <= cps_pkg::CPS_DISC;
      endcase
    end
  end

  // Fault bit: a resume handshake timeout wins over a software clear in the same cycle; bias seen while suspended does not.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault <= 1'b0;
    end else begin
      fault <= (state == cps_pkg::CPS_RESUME && hs_done && !bias) ||
               (state == cps_pkg::CPS_SUSP && bias && !fault_clr) ||
               (fault && !fault_clr);
    end
  end

endmodule

// ---- core/cps_ctrl.sv ----
// Purpose: Two-port cable state control with suspend, resume and power-down logic.
// Assumes: APB slave at 50 MHz; packet events arrive on pclk from the packet layer.
// Notes:   Function
//
// Design decisions made here: register access over APB and the placing of the registers.
`include "cps_consts.svh"

module cps_ctrl #(
  parameter int PD_CYCLES   = `CPS_PD_WAIT_MS * 1000 * `CPS_CLK_MHZ,
  parameter int WAKE_CYCLES = `CPS_WAKE_MS * 1000 * `CPS_CLK_MHZ,
  parameter int HS_CYCLES   = `CPS_BIAS_HS_US * `CPS_CLK_MHZ
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic      [31:0]          prdata,
  output logic                      pslverr,
  // Pins from outside the clock domain
  input  wire logic [1:0]           conn_det_in,
  input  wire logic [1:0]           bias_det_in,
  input  wire logic                 lps_in,
  input  wire logic                 link_clk_in,
  input  wire logic                 suspend_resume_select,
  input  wire logic                 boundary_node,
  // Packet layer: one-pclk event pulses, then peer_legacy, packet_phase and packet_tx levels
  input  wire logic [1:0]           rc_suspend_rx,
  input  wire logic [1:0]           rc_resume_rx,
  input  wire logic                 resume_pkt_rx,
  input  wire logic [1:0]           rx_suspend,
  input  wire logic [1:0]           peer_legacy,
  input  wire logic                 packet_phase,
  input  wire logic                 packet_tx,
  // Cable front end and link side
  output cps_pkg::cps_fe_s [1:0]    port_fe,
  output logic                      confirm_send,
  output logic      [1:0]           bus_reset_req,
  output logic      [1:0]           tx_suspend,
  output logic                      link_on,
  output logic                      power_down
);

  localparam int LINK_IDLE = (`CPS_LINK_IDLE_NS * `CPS_CLK_MHZ) / 1000;
  localparam int PW        = $clog2(PD_CYCLES + 1);
  localparam int WW        = $clog2(WAKE_CYCLES + 1);
  localparam int LW        = $clog2(LINK_IDLE + 1);

  // Elaboration check on the timing counts.
  if (PD_CYCLES < 1 || WAKE_CYCLES < 1 || HS_CYCLES < 1) begin : g_chk
    $error("Timing counts must be at least one cycle");
  end

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  logic [6:0] sync1;
  logic [6:0] sync2;
  logic       lclk_d;

  // Two flops on every pin; only sync2 is read by logic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1  <= '0;
      sync2  <= '0;
      lclk_d <= 1'b0;
    end else begin
      sync1  <= {boundary_node, suspend_resume_select, link_clk_in, lps_in,
                 bias_det_in[1], conn_det_in};
      sync2  <= sync1;
      lclk_d <= sync2[4];
    end
  end

  logic [1:0] conn;
  logic [1:0] bias_raw;
  logic       lps;
  logic       sr_on;
  logic       boundary;
  logic       bias1_raw;

  assign conn      = sync2[1:0];
  assign bias1_raw = sync2[2];
  assign lps       = sync2[3];
  assign sr_on     = sync2[5];
  assign boundary  = sync2[6];

  logic bias0_s1;
  logic bias0_s2;

  // Second port-0 bias synchroniser kept apart to keep the packed vector small.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bias0_s1 <= 1'b0;
      bias0_s2 <= 1'b0;
    end else begin
      bias0_s1 <= bias_det_in[0];
      bias0_s2 <= bias0_s1;
    end
  end

  assign bias_raw = {bias1_raw, bias0_s2};

  // --------------------------------------------------------------------------
  // Link activity from edges of the link clock
  // --------------------------------------------------------------------------
  logic [LW-1:0] idle_cnt;
  logic          link_active;

  // Any edge restarts the idle window; a stopped clock marks the link inactive.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt <= LW'(LINK_IDLE);
    end else if (sync2[4] != lclk_d) begin
      idle_cnt <= '0;
    end else if (idle_cnt != LW'(LINK_IDLE)) begin
      idle_cnt <= idle_cnt + LW'(1);
    end
  end

  assign link_active = (idle_cnt != LW'(LINK_IDLE));

  // --------------------------------------------------------------------------
  // APB register file
  // --------------------------------------------------------------------------
  logic [3:0] ctrl;
  logic [6:0] cmd;
  logic       wr_acc;
  logic       rd_setup;

  assign pready   = 1'b1;
  assign wr_acc   = psel && penable && pwrite;
  assign rd_setup = psel && !penable;

  // Control register: disable and interrupt enable per port.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CPS_CTRL_RESET;
    end else if (wr_acc && paddr == `CPS_OFF_CTRL) begin
      ctrl <= pwdata[3:0];
    end
  end

  // Command register: write-one pulses standing for packets this node receives, plus the per-port fault clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd <= '0;
    end else if (wr_acc && paddr == `CPS_OFF_CMD) begin
      cmd <= pwdata[6:0];
    end else begin
      cmd <= '0;
    end
  end

  cps_pkg::cps_state_e [1:0] st;
  logic [1:0]                fault;
  logic [1:0]                local_res;

  // Read data and error flag are prepared in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (rd_setup) begin
      pslverr <= 1'b0;
      prdata  <= '0;
      unique case (paddr)
        `CPS_OFF_CTRL:   prdata <= {28'h0000000, ctrl};
        `CPS_OFF_CMD:    prdata <= '0;
        `CPS_OFF_STATUS: prdata <= {21'h00000, lps, link_active, power_down, fault,
                                   st[1], st[0]};
        default:         pslverr <= 1'b1;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Suspend and resume decisions
  // --------------------------------------------------------------------------
  logic [1:0] dis;
  logic [1:0] int_en;
  logic [1:0] rc_susp;
  logic [1:0] rc_res;
  logic       res_pkt;
  logic [1:0] fclr;
  logic [1:0] active;
  logic [1:0] susp;
  logic [1:0] bias;
  logic [1:0] go_susp;
  logic [1:0] go_res;
  logic [1:0] prop;

  // With the select low the suspend-resume controls other than the fault clear, and the packets, are ignored.
  assign dis     = sr_on ? ctrl[`CPS_CTRL_DIS_LSB +: 2] : 2'h0;
  assign int_en  = sr_on ? ctrl[`CPS_CTRL_INTEN_LSB +: 2] : 2'h0;
  assign rc_susp = sr_on ? (rc_suspend_rx | cmd[`CPS_CMD_SUSP_LSB +: 2]) : 2'h0;
  assign rc_res  = sr_on ? (rc_resume_rx | cmd[`CPS_CMD_RES_LSB +: 2]) : 2'h0;
  assign res_pkt = sr_on && (resume_pkt_rx || cmd[`CPS_CMD_RPKT_BIT]);
  assign fclr    = cmd[`CPS_CMD_FCLR_LSB +: 2];

  // Disabled ports see no bias at all.
  assign bias = bias_raw & ~dis;

  // Per-port suspend, propagation and resume fan-out.
  for (genvar i = 0; i < 2; i++) begin : g_dec
    assign active[i] = (st[i] == cps_pkg::CPS_ACTIVE);
    assign susp[i]   = (st[i] == cps_pkg::CPS_SUSP);
    // Propagate only to an active port whose peer understands suspend.
    assign prop[i]   = rx_suspend[1-i] && active[1-i] && active[i] &&
                       !peer_legacy[i];
    assign go_susp[i] = (rc_susp[i] || (rx_suspend[i] && sr_on) ||
                         (prop[i] && sr_on)) && active[i];
    assign go_res[i]  = susp[i] && (rc_res[i] || res_pkt ||
                        (local_res[1-i] && !boundary));
  end

  // Confirmation, bus reset and outgoing suspend pulses.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      confirm_send  <= 1'b0;
      bus_reset_req <= '0;
      tx_suspend    <= '0;
    end else begin
      confirm_send  <= |(rc_susp & active);
      bus_reset_req <= {rc_susp[0] && active[0], rc_susp[1] && active[1]};
      tx_suspend    <= sr_on ? prop : 2'h0;
    end
  end

  // --------------------------------------------------------------------------
  // Port instances and front-end enables
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_port
    cps_port #(.HS_CYCLES(HS_CYCLES)) u_port (
      .pclk         (pclk),
      .presetn      (presetn),
      .disable_req  (dis[i]),
      .connect      (conn[i]),
      .bias         (bias[i]),
      .go_suspend   (go_susp[i]),
      .go_resume    (go_res[i]),
      .fault_clr    (fclr[i]),
      .state        (st[i]),
      .fault        (fault[i]),
      .local_resume (local_res[i])
    );

    logic drive;
    logic tx_a;
    logic rx_b;

    // Arbitration is full duplex on both pairs; packets turn the pairs one way.
    assign drive = active[i];
    assign tx_a  = !packet_phase || packet_tx;
    assign rx_b  = !packet_phase || !packet_tx;
    assign port_fe[i].bias_out    = drive || (st[i] == cps_pkg::CPS_RESUME);
    assign port_fe[i].conn_det_en = !port_fe[i].bias_out;
    assign port_fe[i].bias_det_en = drive || susp[i] ||
                                    (st[i] == cps_pkg::CPS_RESUME);
    assign port_fe[i].a_tx_en     = drive && tx_a;
    assign port_fe[i].a_rx_en     = drive && rx_b;
    assign port_fe[i].b_tx_en     = drive && tx_a;
    assign port_fe[i].b_rx_en     = drive && rx_b;
  end

  // --------------------------------------------------------------------------
  // Link interrupt for disabled ports
  // --------------------------------------------------------------------------
  logic [1:0] conn_d;

  // A connection change on a disabled, enabled port raises a one-cycle link_on.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conn_d  <= '0;
      link_on <= 1'b0;
    end else begin
      conn_d  <= conn;
      link_on <= |((conn ^ conn_d) & dis & int_en);
    end
  end

  // --------------------------------------------------------------------------
  // Low power entry and wake
  // --------------------------------------------------------------------------
  logic [PW-1:0] pd_cnt;
  logic [WW-1:0] wk_cnt;
  logic          pd_cond;
  logic          wake;

  assign pd_cond = !(|active) && !lps && !link_active && !link_on;
  assign wake    = lps || link_on || (|(conn ^ conn_d)) || (|(susp & bias));

  // Entry waits out the full quiet window; wake waits the restart time.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pd_cnt     <= '0;
      wk_cnt     <= '0;
      power_down <= 1'b0;
    end else if (!power_down) begin
      wk_cnt <= '0;
      if (!pd_cond) begin
        pd_cnt <= '0;
      end else if (pd_cnt == PW'(PD_CYCLES - 1)) begin
        power_down <= 1'b1;
      end else begin
        pd_cnt <= pd_cnt + PW'(1);
      end
    end else begin
      pd_cnt <= '0;
      if (wk_cnt != '0 || wake) begin
        if (wk_cnt == WW'(WAKE_CYCLES - 1)) begin
          power_down <= 1'b0;
          wk_cnt     <= '0;
        end else begin
          wk_cnt <= wk_cnt + WW'(1);
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_dis_quiet;
    @(posedge pclk) disable iff (!presetn)
      st[0] == cps_pkg::CPS_DISABLE |-> !port_fe[0].bias_out && !port_fe[0].a_tx_en;
  endproperty
  a_dis_quiet: assert property (p_dis_quiet) else $error("Disabled port drives");

  property p_link_on;
    @(posedge pclk) disable iff (!presetn)
      (dis[1] && int_en[1] && conn[1] != conn_d[1]) |=> link_on;
  endproperty
  a_link_on: assert property (p_link_on) else $error("Missing link interrupt");

  property p_susp_quiet;
    @(posedge pclk) disable iff (!presetn)
      susp[0] |-> !port_fe[0].bias_out && port_fe[0].bias_det_en && port_fe[0].conn_det_en;
  endproperty
  a_susp_quiet: assert property (p_susp_quiet) else $error("Suspended port drives");

  property p_remote_susp;
    @(posedge pclk) disable iff (!presetn)
      (rc_suspend_rx[0] && sr_on && active[0]) |=> confirm_send && bus_reset_req[1] &&
                                                   susp[0];
  endproperty
  a_remote_susp: assert property (p_remote_susp) else $error("Remote suspend lost");

  property p_propagate;
    @(posedge pclk) disable iff (!presetn)
      (rx_suspend[0] && sr_on && active[0] && active[1] && !peer_legacy[1])
        |=> tx_suspend[1] && susp[0] && susp[1];
  endproperty
  a_propagate: assert property (p_propagate) else $error("Suspend not propagated");

  property p_legacy_stop;
    @(posedge pclk) disable iff (!presetn)
      peer_legacy[1] |=> !tx_suspend[1];
  endproperty
  a_legacy_stop: assert property (p_legacy_stop) else $error("Suspend sent to legacy");

  property p_sr_off;
    @(posedge pclk) disable iff (!presetn)
      !sr_on |=> !confirm_send && !tx_suspend[0] && !tx_suspend[1];
  endproperty
  a_sr_off: assert property (p_sr_off) else $error("Select low not honoured");

  property p_pd_entry;
    @(posedge pclk) disable iff (!presetn)
      $rose(power_down) |-> $past(pd_cond, 1) && $past(pd_cond, 2);
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("Power down without cause");

  property p_resume_bias;
    @(posedge pclk) disable iff (!presetn)
      (st[0] == cps_pkg::CPS_RESUME && bias[0] && !dis[0]) |=> active[0];
  endproperty
  a_resume_bias: assert property (p_resume_bias) else $error("Resume did not finish");

  cover property (@(posedge pclk) disable iff (!presetn) $rose(susp[0]));
  cover property (@(posedge pclk) disable iff (!presetn) $rose(fault[1]));
  cover property (@(posedge pclk) disable iff (!presetn) $fell(power_down));

endmodule

// ---- verif/cps_peer.sv ----
// Purpose: Peer node at the far end of both cables.
// Assumes: Peer bias answers our bias one pclk later.
// Notes:   A released B side is pulled down, so bias falls to 0.
module cps_peer (
  // Clock
  input  wire logic       pclk,
  // Test control and our bias
  input  wire logic [1:0] attach,
  input  wire logic [1:0] answer,
  input  wire logic [1:0] bias_out,
  // Detector pins
  output logic      [1:0] conn,
  output logic      [1:0] bias
);
  timeunit 1ns;
  timeprecision 1ns;
  // Peer returns bias only while plugged in and willing.
  always @(posedge pclk) bias <= attach & answer & bias_out;
  // The cable itself is what the connection detector sees.
  assign conn = attach;
endmodule

// ---- verif/tb_top.sv ----
// Purpose: Self-checking bench for the cable port state block.
// Assumes: Short counts for power down, wake and bias handshake.
// Notes:   Status is read over APB with no wait states.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, lps_in = 0;
  logic link_clk_in = 0, lk_run = 1, resume_pkt_rx = 0, err, sr = 1, pph = 0;
  logic pready, pslverr, confirm_send, link_on, power_down;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [1:0] conn, bias, attach = 0, answer = 0, rx_suspend = 0, rcs = 0, rcr = 0;
  logic [1:0] bus_reset_req, tx_suspend, leg = 0;
  cps_pkg::cps_fe_s [1:0] port_fe;
  int failures = 0, checked = 0, cyc = 0;
  always #10 pclk = ~pclk;
  always #80 if (lk_run) link_clk_in = ~link_clk_in;
  cps_ctrl #(.PD_CYCLES(20), .WAKE_CYCLES(10), .HS_CYCLES(8)) i_cps_ctrl (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
    .pslverr, .conn_det_in(conn), .bias_det_in(bias), .lps_in, .link_clk_in,
    .suspend_resume_select(sr), .boundary_node(1'b0), .rc_suspend_rx(rcs),
    .rc_resume_rx(rcr), .resume_pkt_rx, .rx_suspend, .peer_legacy(leg),
    .packet_phase(pph), .packet_tx(1'b0), .port_fe, .confirm_send, .bus_reset_req,
    .tx_suspend, .link_on, .power_down);
  cps_peer i_cps_peer (.pclk, .attach, .answer,
    .bias_out({port_fe[1].bias_out, port_fe[0].bias_out}), .conn, .bias);
  task automatic end_sim;
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // One APB transfer; read data and error are taken at the pready edge.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // One idle edge so that the next call never reassigns psel in this step.
    @(posedge pclk);
  endtask
  task automatic st(input int n, input logic [31:0] m, input logic [31:0] e);
    repeat (n) @(posedge pclk);
    bus(1'b0, 12'h008, 32'h0);
    chk("status", rd & m, e);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    st(1, 32'h1FF, 32'h0);
    attach <= 2'h3;
    answer <= 2'h1;
    st(40, 32'hFF, 32'h93);
    answer <= 2'h3;
    resume_pkt_rx <= 1'b1;
    @(posedge pclk) resume_pkt_rx <= 1'b0;
    st(20, 32'h3F, 32'h1B);
    chk("fe1", port_fe[1], 32'h5F);
    pph <= 1'b1;
    @(posedge pclk);
    chk("fe1_pkt", port_fe[1], 32'h55);
    pph <= 1'b0;
    rx_suspend <= 2'h1;
    @(posedge pclk) rx_suspend <= 2'h0;
    #1 chk("txs", tx_suspend, 32'h2);
    st(5, 32'h3F, 32'h12);
    chk("fe0", port_fe[0], 32'h30);
    rcr <= 2'h3;
    @(posedge pclk) rcr <= 2'h0;
    st(20, 32'h3F, 32'h1B);
    sr <= 1'b0;
    repeat (3) @(posedge pclk);
    rcs <= 2'h1;
    @(posedge pclk) rcs <= 2'h0;
    #1 chk("conf_off", {confirm_send, bus_reset_req}, 32'h0);
    @(posedge pclk) sr <= 1'b1;
    st(3, 32'h3F, 32'h1B);
    leg <= 2'h2;
    rx_suspend <= 2'h1;
    @(posedge pclk) rx_suspend <= 2'h0;
    #1 chk("txs_leg", tx_suspend, 32'h0);
    st(5, 32'h3F, 32'h1A);
    leg <= 2'h0;
    rcr <= 2'h1;
    @(posedge pclk) rcr <= 2'h0;
    st(20, 32'h3F, 32'h1B);
    rcs <= 2'h1;
    @(posedge pclk) rcs <= 2'h0;
    #1 chk("conf", {confirm_send, bus_reset_req}, 32'h6);
    st(5, 32'h3F, 32'h1A);
    bus(1'b1, 12'h004, 32'h4);
    st(20, 32'h3F, 32'h1B);
    bus(1'b1, 12'h000, 32'h2);
    st(3, 32'h38, 32'h30);
    chk("fe1", port_fe[1], 32'h20);
    bus(1'b0, 12'h00C, 32'h0);
    chk("slverr", err, 32'h1);
    bus(1'b1, 12'h000, 32'hA);
    attach <= 2'h1;
    repeat (3) @(posedge pclk);
    #1 chk("link_on", link_on, 32'h1);
    @(posedge pclk);
    attach <= 2'h0;
    lk_run = 0;
    bus(1'b1, 12'h000, 32'h0);
    st(300, 32'h13F, 32'h100);
    lps_in <= 1'b1;
    repeat (30) @(posedge pclk);
    chk("pd", power_down, 32'h0);
    end_sim();
  end
endmodule
